// File: rtl/io_expander_pkg.sv
// Package of constants for the 16-bit serial I/O expander
package io_expander_pkg;
   // Fixed upper six bits of the slave address
   localparam logic [5:0] SLAVE_ADDR_HIGH   = 6'h10;
   // Register codes carried in the pointer
   localparam logic [2:0] REG_INPUT_PORT0   = 3'h0;
   localparam logic [2:0] REG_INPUT_PORT1   = 3'h1;
   localparam logic [2:0] REG_OUTPUT_PORT0  = 3'h2;
   localparam logic [2:0] REG_OUTPUT_PORT1  = 3'h3;
   localparam logic [2:0] REG_INVERT_PORT0  = 3'h4;
   localparam logic [2:0] REG_INVERT_PORT1  = 3'h5;
   localparam logic [2:0] REG_DIR_PORT0     = 3'h6;
   localparam logic [2:0] REG_DIR_PORT1     = 3'h7;
   // Reset values
   localparam logic [7:0] OUTPUT_RESET      = 8'hff;
   localparam logic [7:0] INVERT_RESET      = 8'h00;
   localparam logic [7:0] DIR_RESET         = 8'hff;
   localparam logic [7:0] POINTER_RESET     = 8'h00;
   // Field positions
   localparam int         RW_BIT_POS        = 0;
   localparam int         PTR_SEL_MSB       = 2;
   localparam int         PORT_BITS         = 8;
endpackage

// File: rtl/line_sync.sv
// Two-flop synchroniser with edge detection for one serial line
module line_sync
   import io_expander_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   input  wire logic line_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   // Idle bus is high, so reset to one to avoid a false edge
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         last_ff <= 1'b1;
      end else begin
         meta_ff <= line_i;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   // Edges seen only from the second and third stages
   assign level_o = sync_ff;
   assign rise_o  = sync_ff & ~last_ff;
   assign fall_o  = ~sync_ff & last_ff;
endmodule

// File: rtl/port_sync.sv
// Two-flop synchroniser for a byte of port pins
module port_sync
   import io_expander_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic [7:0] pins_i,
   output logic [7:0]      pins_o
);
   logic [7:0] meta_ff;
   logic [7:0] sync_ff;

   // Pins are asynchronous to the core clock
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         meta_ff <= 8'h00;
         sync_ff <= 8'h00;
      end else begin
         meta_ff <= pins_i;
         sync_ff <= meta_ff;
      end
   end

   assign pins_o = sync_ff;
endmodule

// File: rtl/io_expander.sv
// Serial-bus slave, register file and pin drivers of a 16-bit I/O expander
module io_expander
   import io_expander_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       addr_strap_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic [7:0] port0_pin_bit_i,
   input  wire logic [7:0] port1_pin_bit_i,
   output logic [7:0]      pull_high_driver0_o,
   output logic [7:0]      pull_low_driver0_o,
   output logic [7:0]      pull_high_driver1_o,
   output logic [7:0]      pull_low_driver1_o
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_CMD  = 6'h04,
      ST_WDAT = 6'h08,
      ST_RDAT = 6'h10,
      ST_RACK = 6'h20
   } slave_state_t;

   slave_state_t state_ff;
   logic         scl_lvl;
   logic         scl_rise;
   logic         scl_fall;
   logic         sda_lvl;
   logic         sda_rise;
   logic         sda_fall;
   logic [7:0]   port0_sensed_bit;
   logic [7:0]   port1_sensed_bit;
   logic [7:0]   port0_drive_bit_ff;
   logic [7:0]   port1_drive_bit_ff;
   logic [7:0]   port0_invert_bit_ff;
   logic [7:0]   port1_invert_bit_ff;
   logic [7:0]   port0_direction_bit_ff;
   logic [7:0]   port1_direction_bit_ff;
   logic [7:0]   pointer_ff;
   logic [7:0]   shift_ff;
   logic [3:0]   bit_cnt_ff;
   logic         ack_phase_ff;
   logic         rw_ff;
   logic         strap_ff;
   logic         strap_meta_ff;
   logic         sda_o_ff;
   logic         sda_oe_ff;
   logic         start_cond;
   logic         stop_cond;
   logic         byte_done;
   logic [2:0]   sel;
   logic [2:0]   nxt_sel;
   logic [7:0]   read_data;
   logic [7:0]   port0_view;
   logic [7:0]   port1_view;

   // Register read mux, shared by first and later read bytes
   function automatic logic [7:0] reg_read(input logic [2:0] idx,
                                           input logic [7:0] in0,
                                           input logic [7:0] in1);
      logic [7:0] val;
      val = 8'h00;
      case (idx)
         REG_INPUT_PORT0:  val = in0;
         REG_INPUT_PORT1:  val = in1;
         REG_OUTPUT_PORT0: val = port0_drive_bit_ff;
         REG_OUTPUT_PORT1: val = port1_drive_bit_ff;
         REG_INVERT_PORT0: val = port0_invert_bit_ff;
         REG_INVERT_PORT1: val = port1_invert_bit_ff;
         REG_DIR_PORT0:    val = port0_direction_bit_ff;
         default:          val = port1_direction_bit_ff;
      endcase
      return val;
   endfunction

   // Own address check, used by the state machine and the ack drive
   function automatic logic addr_match(input logic [7:0] rx,
                                       input logic       strap);
      return rx[7:1] == {SLAVE_ADDR_HIGH, strap};
   endfunction

   // Serial lines and pins come from outside the clock domain
   line_sync u_scl_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .line_i    (scl_i),
      .level_o   (scl_lvl),
      .rise_o    (scl_rise),
      .fall_o    (scl_fall)
   );

   line_sync u_sda_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .line_i    (sda_i),
      .level_o   (sda_lvl),
      .rise_o    (sda_rise),
      .fall_o    (sda_fall)
   );

   port_sync u_port0_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .pins_i    (port0_pin_bit_i),
      .pins_o    (port0_sensed_bit)
   );

   port_sync u_port1_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .pins_i    (port1_pin_bit_i),
      .pins_o    (port1_sensed_bit)
   );

   // Strap is a pin like the others, so it also passes two flops
   always_ff @(posedge sys_clk_i) begin
      strap_meta_ff <= addr_strap_i;
      strap_ff      <= strap_meta_ff;
   end

   // Bus conditions: data moves while clock is high
   assign start_cond = sda_fall & scl_lvl;
   assign stop_cond  = sda_rise & scl_lvl;
   assign byte_done  = scl_rise & (bit_cnt_ff == 4'd7);

   // Inverted view of pins; bit n is pin n
   assign port0_view = port0_sensed_bit ^ port0_invert_bit_ff;
   assign port1_view = port1_sensed_bit ^ port1_invert_bit_ff;

   // Only the low three pointer bits select a register
   assign sel     = pointer_ff[PTR_SEL_MSB:0];
   assign nxt_sel = {sel[2:1], ~sel[0]};
   assign read_data = reg_read(sel, port0_view, port1_view);

   // Bit counter and ack phase tracking
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         bit_cnt_ff   <= 4'd0;
         ack_phase_ff <= 1'b0;
      end else if (start_cond || stop_cond) begin
         bit_cnt_ff   <= 4'd0;
         ack_phase_ff <= 1'b0;
      end else if (scl_fall && state_ff != ST_IDLE) begin
         if (ack_phase_ff) begin
            ack_phase_ff <= 1'b0;
            bit_cnt_ff   <= 4'd0;
         end else if (bit_cnt_ff == 4'd8) begin
            ack_phase_ff <= 1'b1;
         end
      end else if (scl_rise && !ack_phase_ff && state_ff != ST_IDLE) begin
         bit_cnt_ff <= bit_cnt_ff + 4'd1;
      end
   end

   // Receive shifter samples on clock rise
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         shift_ff <= 8'h00;
      end else if (scl_rise && !ack_phase_ff) begin
         shift_ff <= {shift_ff[6:0], sda_lvl};
      end
   end

   // Slave state machine; decisions at end of each byte
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state_ff <= ST_IDLE;
         rw_ff    <= 1'b0;
      end else if (start_cond) begin
         state_ff <= ST_ADDR;
      end else if (stop_cond) begin
         state_ff <= ST_IDLE;
      end else if (scl_fall && bit_cnt_ff == 4'd8 && !ack_phase_ff) begin
         case (state_ff)
            ST_ADDR: begin
               if (addr_match(shift_ff, strap_ff)) begin
                  rw_ff    <= shift_ff[RW_BIT_POS];
                  state_ff <= shift_ff[RW_BIT_POS] ? ST_RDAT : ST_CMD;
               end else begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_CMD:  state_ff <= ST_WDAT;
            ST_WDAT: state_ff <= ST_WDAT;
            ST_RDAT: state_ff <= ST_RACK;
            default: state_ff <= state_ff;
         endcase
      end else if (state_ff == ST_RACK && scl_rise) begin
         // Master nack ends the read; ack asks for another byte
         state_ff <= sda_lvl ? ST_IDLE : ST_RDAT;
      end
   end

   // Pointer: loaded by command byte, steps within pair per written byte and per master-acked read byte
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pointer_ff <= POINTER_RESET;
      end else if (byte_done && state_ff == ST_CMD) begin
         pointer_ff <= {shift_ff[6:0], sda_lvl};
      end else if (byte_done && state_ff == ST_WDAT) begin
         pointer_ff <= {pointer_ff[7:3], nxt_sel};
      end else if (state_ff == ST_RACK && scl_rise && !sda_lvl) begin
         pointer_ff <= {pointer_ff[7:3], nxt_sel};
      end
   end

   // Writable registers; input codes are dropped
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         port0_drive_bit_ff     <= OUTPUT_RESET;
         port1_drive_bit_ff     <= OUTPUT_RESET;
         port0_invert_bit_ff    <= INVERT_RESET;
         port1_invert_bit_ff    <= INVERT_RESET;
         port0_direction_bit_ff <= DIR_RESET;
         port1_direction_bit_ff <= DIR_RESET;
      end else if (byte_done && state_ff == ST_WDAT) begin
         case (sel)
            REG_OUTPUT_PORT0: port0_drive_bit_ff <= {shift_ff[6:0], sda_lvl};
            REG_OUTPUT_PORT1: port1_drive_bit_ff <= {shift_ff[6:0], sda_lvl};
            REG_INVERT_PORT0: port0_invert_bit_ff <= {shift_ff[6:0], sda_lvl};
            REG_INVERT_PORT1: port1_invert_bit_ff <= {shift_ff[6:0], sda_lvl};
            REG_DIR_PORT0: port0_direction_bit_ff <= {shift_ff[6:0], sda_lvl};
            REG_DIR_PORT1: port1_direction_bit_ff <= {shift_ff[6:0], sda_lvl};
            default: ;
         endcase
      end
   end

   // Serial data drive: acks, then read data MSB first on clock fall
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         sda_o_ff  <= 1'b1;
         sda_oe_ff <= 1'b0;
      end else if (start_cond || stop_cond) begin
         sda_oe_ff <= 1'b0;
      end else if (scl_fall) begin
         if (!ack_phase_ff && bit_cnt_ff == 4'd8) begin
            // Ack own address, command and written bytes
            if ((state_ff == ST_ADDR &&
                 addr_match(shift_ff, strap_ff)) ||
                state_ff == ST_CMD || state_ff == ST_WDAT) begin
               sda_o_ff  <= 1'b0;
               sda_oe_ff <= 1'b1;
            end else begin
               sda_oe_ff <= 1'b0;
            end
         end else if (ack_phase_ff && rw_ff && state_ff == ST_RDAT) begin
            // First read bit leaves as the ack bit ends
            sda_o_ff  <= read_data[7];
            sda_oe_ff <= ~read_data[7];
         end else if (state_ff == ST_RDAT && !ack_phase_ff &&
                      bit_cnt_ff < 4'd8) begin
            sda_o_ff  <= read_data[3'd7 - bit_cnt_ff[2:0]];
            sda_oe_ff <= ~read_data[3'd7 - bit_cnt_ff[2:0]];
         end else begin
            sda_oe_ff <= 1'b0;
         end
      end
   end

   // Open drain: only low is driven, high is released
   assign sda_o    = 1'b0;
   assign sda_oe_o = sda_oe_ff & ~sda_o_ff;

   // Pin drivers per bit
   genvar gi;
   generate
      for (gi = 0; gi < PORT_BITS; gi++) begin : g_pin
         // Input: both drivers off; output: exactly one on
         assign pull_high_driver0_o[gi] = ~port0_direction_bit_ff[gi] &
                                          port0_drive_bit_ff[gi];
         assign pull_low_driver0_o[gi]  = ~port0_direction_bit_ff[gi] &
                                          ~port0_drive_bit_ff[gi];
         assign pull_high_driver1_o[gi] = ~port1_direction_bit_ff[gi] &
                                          port1_drive_bit_ff[gi];
         assign pull_low_driver1_o[gi]  = ~port1_direction_bit_ff[gi] &
                                          ~port1_drive_bit_ff[gi];
      end
   endgenerate
endmodule

// File: testbench/io_expander_asserts.sv
// Port-level checks for the I/O expander
module io_expander_asserts (
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       sda_oe_o,
   input  wire logic [7:0] pull_high_driver0_o,
   input  wire logic [7:0] pull_low_driver0_o,
   input  wire logic [7:0] pull_high_driver1_o,
   input  wire logic [7:0] pull_low_driver1_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] drv;
   // All pin drivers in one word
   assign drv = {pull_high_driver0_o, pull_low_driver0_o,
                 pull_high_driver1_o, pull_low_driver1_o};
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_excl_port0: assert property (
      (pull_high_driver0_o & pull_low_driver0_o) == 8'h00)
      else $error("port 0 pin driven both ways");
   a_excl_port1: assert property (
      (pull_high_driver1_o & pull_low_driver1_o) == 8'h00)
      else $error("port 1 pin driven both ways");
   // Reset itself must be checked, so no disable here
   a_reset_quiet: assert property (disable iff (1'b0)
      !rstn_i |=> drv == 32'h0 && !sda_oe_o)
      else $error("driver on during reset");
   a_reset_inputs: assert property (
      $rose(rstn_i) |-> (drv == 32'h0) [*8])
      else $error("pin driven right after reset");
   // Data may only move while the bus clock is low
   a_sda_scl_low: assert property (
      $changed(sda_oe_o) |-> !scl_i)
      else $error("data changed with clock high");
   // Open drain: while the device pulls, the data wire must read low
   a_open_drain: assert property (
      sda_oe_o |-> !sda_i)
      else $error("data not pulled low");
   a_start_free: assert property (
      scl_i && $fell(sda_i) |=> (!sda_oe_o) [*8])
      else $error("data pulled during address");
   // Slack of five covers the two-flop clock sync
   a_drv_by_bus: assert property (
      $changed(drv) |-> !(scl_i && $past(scl_i, 5)))
      else $error("driver changed without bus clock");
   c_ack: cover property ($rose(sda_oe_o));
   c_high: cover property (pull_high_driver0_o != 8'h00);
   c_low: cover property (pull_low_driver1_o != 8'h00);
endmodule
bind io_expander io_expander_asserts u_chk (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_oe_o(sda_oe_o),
   .pull_high_driver0_o(pull_high_driver0_o),
   .pull_low_driver0_o(pull_low_driver0_o),
   .pull_high_driver1_o(pull_high_driver1_o),
   .pull_low_driver1_o(pull_low_driver1_o));

// File: testbench/bus_master_model.sv
// Serial bus master model for the expander
module bus_master_model (
   input  wire logic sys_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus, both lines released high
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // Start (a=1) or stop (a=0): data moves with clock high
   task automatic cond(input logic a);
      w(5);
      sda_o = a;
      w(3);
      scl_o = 1'b1;
      w(8);
      sda_o = ~a;
      w(8);
      if (a) scl_o = 1'b0;
   endtask
   // Data set late in low phase, so device release lands first
   task automatic bit_cell(input logic b, output logic r);
      w(5);
      sda_o = b;
      w(3);
      scl_o = 1'b1;
      w(7);
      r = sda_i;
      w(1);
      scl_o = 1'b0;
   endtask
   // Byte out MSB first; ack is data pulled low
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_cell(b[i], r);
      bit_cell(1'b1, r);
      ack = ~r;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_cell(1'b1, r);
         b[i] = r;
      end
      bit_cell(last, r);
   endtask
endmodule

// File: testbench/test_io_expander.sv
// Self-checking bench for the 16-bit I/O expander
`define CHK(what, exp, got) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
      end \
   end
module test_io_expander
   import io_expander_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk;
   logic       rstn;
   logic       strap;
   logic       scl;
   logic       sda_m;
   logic       sda_out;
   logic       sda_oe;
   wire        sda_wire;
   logic [7:0] ext0, ext1, pin0, pin1, ph0, pl0, ph1, pl1;
   logic [7:0] rd [4];
   int         failures;
   int         num_checks;
   // Pull-up data wire; a pin follows whichever driver is on
   assign sda_wire = sda_m & ~(sda_oe & ~sda_out);
   assign pin0 = (ext0 & ~pl0) | ph0;
   assign pin1 = (ext1 & ~pl1) | ph1;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   bus_master_model M (.sys_clk_i(clk), .sda_i(sda_wire), .scl_o(scl),
      .sda_o(sda_m));
   io_expander DUT (.sys_clk_i(clk), .rstn_i(rstn), .addr_strap_i(strap),
      .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_out), .sda_oe_o(sda_oe),
      .port0_pin_bit_i(pin0), .port1_pin_bit_i(pin1),
      .pull_high_driver0_o(ph0), .pull_low_driver0_o(pl0),
      .pull_high_driver1_o(ph1), .pull_low_driver1_o(pl1));
   task automatic end_of_test();
      if (failures == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Write address, then command byte into the pointer
   task automatic head(input logic [7:0] cmd);
      logic ack;
      M.cond(1'b1);
      M.send_byte({SLAVE_ADDR_HIGH, strap, 1'b0}, ack);
      `CHK("write addr ack", 1'b1, ack)
      M.send_byte(cmd, ack);
      `CHK("command ack", 1'b1, ack)
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic ack;
      head(cmd);
      M.send_byte(d[15:8], ack);
      `CHK("first data ack", 1'b1, ack)
      M.send_byte(d[7:0], ack);
      `CHK("second data ack", 1'b1, ack)
      M.cond(1'b0);
   endtask
   // Restart with read bit, n bytes, last one not acknowledged
   task automatic rdn(input logic [7:0] cmd, input int n);
      logic ack;
      head(cmd);
      M.cond(1'b1);
      M.send_byte({SLAVE_ADDR_HIGH, strap, 1'b1}, ack);
      `CHK("read addr ack", 1'b1, ack)
      for (int i = 0; i < n; i++) M.get_byte(i == n - 1, rd[i]);
      M.cond(1'b0);
   endtask
   task automatic t_defaults();
      logic [7:0] exp [3] = '{8'hff, 8'h00, 8'hff};
      `CHK("drivers", 32'h0, {ph0, pl0, ph1, pl1})
      for (int k = 0; k < 3; k++) begin
         rdn(8'h02 + 8'(2 * k), 2);
         `CHK("default lo", exp[k], rd[0])
         `CHK("default hi", exp[k], rd[1])
      end
   endtask
   task automatic t_addr();
      logic ack;
      M.cond(1'b1);
      M.send_byte({SLAVE_ADDR_HIGH, ~strap, 1'b0}, ack);
      `CHK("other addr ack", 1'b0, ack)
      M.cond(1'b0);
   endtask
   // Pair alternation; only direction-zero pins are driven
   task automatic t_pair();
      wr(8'h03, 16'ha53c);
      wr(8'h06, 16'h0ff0);
      `CHK("drivers", 32'h30c0050a, {ph0, pl0, ph1, pl1})
      rdn(8'h02, 3);
      `CHK("out pair", 24'h3ca53c, {rd[0], rd[1], rd[2]})
   endtask
   // Pins seen through inversion; input writes change nothing
   task automatic t_input();
      ext0 = 8'h5a;
      ext1 = 8'hc3;
      wr(8'hfc, 16'hff0f);
      rdn(8'hf8, 2);
      `CHK("inputs", 16'hc5ca, {rd[0], rd[1]})
      wr(8'h00, 16'h1234);
      rdn(8'h03, 2);
      `CHK("outputs kept", 16'ha53c, {rd[0], rd[1]})
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      end_of_test();
   end
   initial begin
      rstn = 1'b0;
      strap = 1'b0;
      ext0 = 8'h00;
      ext1 = 8'h00;
      failures = 0;
      num_checks = 0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      t_defaults();
      t_addr();
      strap = 1'b1;
      t_pair();
      t_input();
      // Second reset in mid-run must restore every default
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("reset drivers", 32'h0, {ph0, pl0, ph1, pl1})
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      t_defaults();
      end_of_test();
   end
endmodule
